// ---- design/sncfr_pkg.sv ----
// Constants, field layouts and carrier types of the serial NAND command block.
// Assumes a 40 MHz system clock and a serial clock from the host controller.
`default_nettype none

package sncfr_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_GET_FEAT    = 8'h0f;
  localparam logic [7:0] OP_SET_FEAT    = 8'h1f;
  localparam logic [7:0] OP_PAGE_READ   = 8'h13;
  localparam logic [7:0] OP_READ_X1A    = 8'h03;
  localparam logic [7:0] OP_READ_X1B    = 8'h0b;
  localparam logic [7:0] OP_READ_X2     = 8'h3b;
  localparam logic [7:0] OP_READ_X4     = 8'h6b;
  localparam logic [7:0] OP_SEQ_READ    = 8'h31;
  localparam logic [7:0] OP_SEQ_END     = 8'h3f;
  localparam logic [7:0] OP_READ_ID     = 8'h9f;
  localparam logic [7:0] OP_PROG_EXEC   = 8'h10;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_RESET       = 8'hff;

  // ----------------------------------------------------------------
  // Feature register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] FEAT_BLOCK_PROTECTION = 8'ha0;
  localparam logic [7:0] FEAT_CONFIGURATION    = 8'hb0;
  localparam logic [7:0] FEAT_STATUS           = 8'hc0;
  localparam int         PROT_WRITE_LOCK_BIT   = 7;
  localparam int         PROT_SOLID_BIT        = 0;
  localparam logic [7:0] PROT_WRITE_MASK       = 8'hbf;
  localparam logic [7:0] PROT_SOLID_KEEP       = 8'h3f;
  localparam logic [7:0] PROT_RESET            = 8'h00;
  localparam int         CFG_QUAD_SELECT_BIT   = 0;
  localparam logic [7:0] CFG_WRITE_MASK        = 8'hd1;
  localparam logic [7:0] CFG_RESET             = 8'h10;

  // Identification bytes; both values are arbitrary.
  localparam logic [7:0] ID_MAKER  = 8'h5a;
  localparam logic [7:0] ID_DEVICE = 8'h3c;

  // ----------------------------------------------------------------
  // Page geometry and wrap windows
  // ----------------------------------------------------------------
  localparam logic [12:0] PAGE_BYTES  = 13'd2112;
  localparam logic [11:0] PAGE_LAST   = 12'd2111;
  localparam logic [11:0] WRAP_LEN_00 = 12'd2112;
  localparam logic [11:0] WRAP_LEN_01 = 12'd2048;
  localparam logic [11:0] WRAP_LEN_10 = 12'd64;
  localparam logic [11:0] WRAP_LEN_11 = 12'd16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 25;
  localparam int ARRAY_READ_TIME_NS    = 25000;
  localparam int CACHE_BUSY_TIME_NS    = 5000;
  localparam int RESET_TIME_NS         = 5000;
  localparam int ARRAY_READ_CYCLES     = (ARRAY_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CACHE_BUSY_CYCLES     = (CACHE_BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYCLES          = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_TIME_NS       = 200000;
  localparam int ERASE_TIME_NS         = 1000000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] bits;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } sncfr_frame_t;

  typedef struct packed {
    logic [7:0] prot;
    logic [7:0] cfg;
    logic [7:0] stat;
    logic       bank;
  } sncfr_feat_t;

  typedef enum logic [1:0] {WID_X1, WID_X2, WID_X4} sncfr_width_t;

  typedef enum {SEQ_IDLE, SEQ_LOAD, SEQ_RESET, SEQ_MODIFY} sncfr_state_t;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] sncfrAddrEnd(input logic [7:0] op);
    unique case (op)
      OP_GET_FEAT, OP_SET_FEAT:                        sncfrAddrEnd = 12'd16;
      OP_READ_X1A, OP_READ_X1B, OP_READ_X2, OP_READ_X4: sncfrAddrEnd = 12'd24;
      OP_PAGE_READ, OP_BLOCK_ERASE:                    sncfrAddrEnd = 12'd32;
      default:                                         sncfrAddrEnd = 12'd8;
    endcase
  endfunction : sncfrAddrEnd

  function automatic logic [11:0] sncfrWrapNext(input logic [11:0] col, input logic [1:0] sel);
    logic [11:0] base;
    logic [11:0] len;
    base = 12'h000;
    len  = WRAP_LEN_00;
    unique case (sel)
      2'b00: len = WRAP_LEN_00;
      2'b01: len = WRAP_LEN_01;
      2'b10: begin
        base = {col[11:6], 6'h00};
        len  = WRAP_LEN_10;
      end
      2'b11: begin
        base = {col[11:4], 4'h0};
        len  = WRAP_LEN_11;
      end
    endcase
    sncfrWrapNext = (col + 12'h001 >= base + len) ? base : col + 12'h001;
  endfunction : sncfrWrapNext

endpackage : sncfr_pkg

`default_nettype wire

// ---- design/sncfr_core.sv ----
// Serial NAND command, feature and cache read logic as seen inside the flash.
// Assumes the host drives chip select and the serial clock; the serial clock
// only runs inside frames, and arst_n low stands for a power cycle.
`default_nettype none

module sncfr_core #(
  parameter int PROG_CYCLES  = sncfr_pkg::PROGRAM_TIME_NS / sncfr_pkg::CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = sncfr_pkg::ERASE_TIME_NS / sncfr_pkg::CLK_PERIOD_NS
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic [3:0] sioIn,
  output var  logic [3:0] sioOut,
  output var  logic [3:0] sioOe
);

  // ----------------------------------------------------------------
  // Serial clock domain: frame capture
  // ----------------------------------------------------------------
  sncfr_pkg::sncfr_frame_t frm_reg;
  sncfr_pkg::sncfr_feat_t  featS1_reg;
  sncfr_pkg::sncfr_feat_t  featS2_reg;
  sncfr_pkg::sncfr_feat_t  featSnap;
  logic                    frameRstN;
  logic                    inFrame_reg;

  // A capture stands from chip select rising until the next frame's first edge.
  assign frameRstN = arst_n & ~csN;

  always_ff @(posedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      inFrame_reg <= 1'b0;
    end else begin
      inFrame_reg <= 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      frm_reg <= '0;
    end else if (!inFrame_reg) begin
      frm_reg <= '{12'd1, {7'h00, sioIn[0]}, 24'h0, 8'h00};
    end else begin
      if (frm_reg.bits != 12'hfff) begin
        frm_reg.bits <= frm_reg.bits + 12'd1;
      end
      if (frm_reg.bits < 12'd8) begin
        frm_reg.op <= {frm_reg.op[6:0], sioIn[0]};
      end else if (frm_reg.bits < sncfr_pkg::sncfrAddrEnd(frm_reg.op)) begin
        frm_reg.addr <= {frm_reg.addr[22:0], sioIn[0]};
      end else if (frm_reg.op == sncfr_pkg::OP_SET_FEAT && frm_reg.bits < 12'd24) begin
        frm_reg.wdata <= {frm_reg.wdata[6:0], sioIn[0]};
      end
    end
  end

  // Feature snapshot crossing; prot and cfg only change between frames, stat and bank change whenever the sequencer moves.
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      featS1_reg <= '0;
      featS2_reg <= '0;
    end else begin
      featS1_reg <= featSnap;
      featS2_reg <= featS1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial clock domain: output decode
  // ----------------------------------------------------------------
  sncfr_pkg::sncfr_width_t outWidth;
  logic                    outCmd;
  logic [11:0]             outStart;
  logic [7:0]              srcByte;
  logic [7:0]              outSh_reg;
  logic [2:0]              left_reg;
  logic [11:0]             ptr_reg;
  logic                    started_reg;
  logic [11:0]             curIdx;
  logic [12:0]             memRdIdx;
  logic [7:0]              cacheMem [0:2*sncfr_pkg::PAGE_BYTES-1];

  always_comb begin
    outWidth = sncfr_pkg::WID_X1;
    outCmd   = 1'b0;
    outStart = 12'd16;
    unique case (frm_reg.op)
      sncfr_pkg::OP_GET_FEAT: begin
        outCmd = 1'b1;
      end
      sncfr_pkg::OP_READ_ID: begin
        outCmd = 1'b1;
      end
      sncfr_pkg::OP_READ_X1A, sncfr_pkg::OP_READ_X1B: begin
        outCmd   = 1'b1;
        outStart = 12'd32;
      end
      sncfr_pkg::OP_READ_X2: begin
        outCmd   = 1'b1;
        outStart = 12'd32;
        outWidth = sncfr_pkg::WID_X2;
      end
      sncfr_pkg::OP_READ_X4: begin
        outCmd   = featS2_reg.cfg[sncfr_pkg::CFG_QUAD_SELECT_BIT];
        outStart = 12'd32;
        outWidth = sncfr_pkg::WID_X4;
      end
      default: outCmd = 1'b0;
    endcase
  end

  assign curIdx   = started_reg ? ptr_reg : frm_reg.addr[11:0];
  assign memRdIdx = featS2_reg.bank ? {1'b0, curIdx} + sncfr_pkg::PAGE_BYTES : {1'b0, curIdx};

  always_comb begin
    unique case (frm_reg.op)
      sncfr_pkg::OP_GET_FEAT: begin
        unique case (frm_reg.addr[7:0])
          sncfr_pkg::FEAT_BLOCK_PROTECTION: srcByte = featS2_reg.prot;
          sncfr_pkg::FEAT_CONFIGURATION:    srcByte = featS2_reg.cfg;
          sncfr_pkg::FEAT_STATUS:           srcByte = featS2_reg.stat;
          default:                          srcByte = 8'h00;
        endcase
      end
      sncfr_pkg::OP_READ_ID: srcByte = started_reg ? sncfr_pkg::ID_DEVICE : sncfr_pkg::ID_MAKER;
      default:               srcByte = cacheMem[memRdIdx];
    endcase
  end

  // Output bits change on the falling edge, once the header has been taken.
  always_ff @(negedge sclk or negedge frameRstN) begin
    if (!frameRstN) begin
      sioOut      <= 4'h0;
      sioOe       <= 4'h0;
      outSh_reg   <= 8'h00;
      left_reg    <= 3'd0;
      ptr_reg     <= 12'd0;
      started_reg <= 1'b0;
    end else if (inFrame_reg && outCmd && frm_reg.bits >= outStart) begin
      if (left_reg == 3'd0) begin
        started_reg <= 1'b1;
        ptr_reg     <= sncfr_pkg::sncfrWrapNext(curIdx, frm_reg.addr[13:12]);
        unique case (outWidth)
          sncfr_pkg::WID_X1: begin
            sioOut    <= {2'b00, srcByte[7], 1'b0};
            sioOe     <= 4'b0010;
            outSh_reg <= {srcByte[6:0], 1'b0};
            left_reg  <= 3'd7;
          end
          sncfr_pkg::WID_X2: begin
            sioOut    <= {2'b00, srcByte[7:6]};
            sioOe     <= 4'b0011;
            outSh_reg <= {srcByte[5:0], 2'b00};
            left_reg  <= 3'd3;
          end
          sncfr_pkg::WID_X4: begin
            sioOut    <= srcByte[7:4];
            sioOe     <= 4'b1111;
            outSh_reg <= {srcByte[3:0], 4'h0};
            left_reg  <= 3'd1;
          end
          default: begin
            sioOut    <= 4'h0;
            sioOe     <= 4'h0;
            outSh_reg <= 8'h00;
            left_reg  <= 3'd0;
          end
        endcase
      end else begin
        left_reg <= left_reg - 3'd1;
        unique case (outWidth)
          sncfr_pkg::WID_X1: begin
            sioOut    <= {2'b00, outSh_reg[7], 1'b0};
            outSh_reg <= {outSh_reg[6:0], 1'b0};
          end
          sncfr_pkg::WID_X2: begin
            sioOut    <= {2'b00, outSh_reg[7:6]};
            outSh_reg <= {outSh_reg[5:0], 2'b00};
          end
          default: begin
            sioOut    <= outSh_reg[7:4];
            outSh_reg <= {outSh_reg[3:0], 4'h0};
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: synchronisers and command take-over
  // ----------------------------------------------------------------
  logic                   csS1_reg;
  logic                   csS2_reg;
  logic                   csS3_reg;
  logic                   wpS1_reg;
  logic                   wpS2_reg;
  logic                   cmdGo;
  logic                   idle;
  logic                   quad;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      csS1_reg <= 1'b1;
      csS2_reg <= 1'b1;
      csS3_reg <= 1'b1;
      wpS1_reg <= 1'b1;
      wpS2_reg <= 1'b1;
    end else begin
      csS1_reg <= csN;
      csS2_reg <= csS1_reg;
      csS3_reg <= csS2_reg;
      wpS1_reg <= sioIn[2];
      wpS2_reg <= wpS1_reg;
    end
  end

  // The frame fields are stable once chip select is high and seen twice.
  assign cmdGo = csS2_reg & ~csS3_reg;

  // ----------------------------------------------------------------
  // System domain: busy sequencer and cache fill
  // ----------------------------------------------------------------
  sncfr_pkg::sncfr_state_t seqState_reg;
  logic [16:0]             cnt_reg;
  logic [11:0]             fill_reg;
  logic                    fillDone_reg;
  logic [16:0]             row_reg;
  logic                    bank_reg;
  logic                    seqOn_reg;
  logic                    cacheBusy_reg;
  logic                    welReg;
  logic [7:0]              protReg;
  logic [7:0]              cfgReg;
  logic                    seqCmd;
  logic                    modCmd;

  assign idle   = (seqState_reg == sncfr_pkg::SEQ_IDLE);
  assign seqCmd = cmdGo && idle && seqOn_reg &&
                  (frm_reg.op == sncfr_pkg::OP_SEQ_READ || frm_reg.op == sncfr_pkg::OP_SEQ_END);
  assign modCmd = cmdGo && idle && welReg &&
                  ((frm_reg.op == sncfr_pkg::OP_PROG_EXEC && frm_reg.bits >= 12'd32) ||
                   (frm_reg.op == sncfr_pkg::OP_BLOCK_ERASE && frm_reg.bits >= 12'd32));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seqState_reg  <= sncfr_pkg::SEQ_LOAD;
      cnt_reg       <= 17'(sncfr_pkg::ARRAY_READ_CYCLES);
      row_reg       <= 17'd0;
      bank_reg      <= 1'b1;
      seqOn_reg     <= 1'b0;
      cacheBusy_reg <= 1'b0;
    end else if (cmdGo && frm_reg.op == sncfr_pkg::OP_RESET && frm_reg.bits >= 12'd8) begin
      seqState_reg  <= sncfr_pkg::SEQ_RESET;
      cnt_reg       <= 17'(sncfr_pkg::RESET_CYCLES);
      seqOn_reg     <= 1'b0;
      cacheBusy_reg <= 1'b0;
    end else begin
      unique case (seqState_reg)
        sncfr_pkg::SEQ_IDLE: begin
          if (cmdGo && frm_reg.op == sncfr_pkg::OP_PAGE_READ && frm_reg.bits >= 12'd32) begin
            seqState_reg <= sncfr_pkg::SEQ_LOAD;
            cnt_reg      <= 17'(sncfr_pkg::ARRAY_READ_CYCLES);
            row_reg      <= frm_reg.addr[16:0];
            seqOn_reg    <= 1'b1;
          end else if (seqCmd) begin
            seqState_reg  <= sncfr_pkg::SEQ_LOAD;
            cnt_reg       <= 17'(sncfr_pkg::CACHE_BUSY_CYCLES);
            row_reg       <= row_reg + 17'd1;
            cacheBusy_reg <= 1'b1;
            seqOn_reg     <= (frm_reg.op == sncfr_pkg::OP_SEQ_READ);
          end else if (modCmd) begin
            seqState_reg <= sncfr_pkg::SEQ_MODIFY;
            cnt_reg      <= (frm_reg.op == sncfr_pkg::OP_PROG_EXEC) ? 17'(PROG_CYCLES)
                                                                    : 17'(ERASE_CYCLES);
          end
        end
        sncfr_pkg::SEQ_LOAD: begin
          if (cnt_reg != 17'd0) begin
            cnt_reg <= cnt_reg - 17'd1;
          end else if (fillDone_reg) begin
            seqState_reg  <= sncfr_pkg::SEQ_IDLE;
            bank_reg      <= ~bank_reg;
            cacheBusy_reg <= 1'b0;
          end
        end
        sncfr_pkg::SEQ_RESET, sncfr_pkg::SEQ_MODIFY: begin
          if (cnt_reg != 17'd0) begin
            cnt_reg <= cnt_reg - 17'd1;
          end else begin
            seqState_reg <= sncfr_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // The fill writes the bank that is not being read, so the prior page stays visible.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fill_reg     <= 12'd0;
      fillDone_reg <= 1'b0;
    end else if (seqState_reg != sncfr_pkg::SEQ_LOAD) begin
      fill_reg     <= 12'd0;
      fillDone_reg <= 1'b0;
    end else if (!fillDone_reg) begin
      fill_reg     <= fill_reg + 12'd1;
      fillDone_reg <= (fill_reg == sncfr_pkg::PAGE_LAST);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (seqState_reg == sncfr_pkg::SEQ_LOAD && !fillDone_reg) begin
      cacheMem[bank_reg ? {1'b0, fill_reg} : {1'b0, fill_reg} + sncfr_pkg::PAGE_BYTES] <=
        row_reg[7:0] ^ fill_reg[7:0] ^ {4'h0, fill_reg[11:8]};
    end
  end

  // ----------------------------------------------------------------
  // System domain: write latch and feature registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      welReg <= 1'b0;
    end else if (cmdGo && idle && frm_reg.bits >= 12'd8 && frm_reg.op == sncfr_pkg::OP_LATCH_SET) begin
      welReg <= 1'b1;
    end else if (cmdGo && idle && frm_reg.bits >= 12'd8 &&
                 frm_reg.op == sncfr_pkg::OP_LATCH_CLEAR) begin
      welReg <= 1'b0;
    end else if (seqState_reg == sncfr_pkg::SEQ_MODIFY && cnt_reg == 17'd0) begin
      welReg <= 1'b0;
    end
  end

  assign quad = cfgReg[sncfr_pkg::CFG_QUAD_SELECT_BIT];

  // Only power-up reset touches these; the reset command does not.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      protReg <= sncfr_pkg::PROT_RESET;
      cfgReg  <= sncfr_pkg::CFG_RESET;
    end else if (cmdGo && idle && frm_reg.op == sncfr_pkg::OP_SET_FEAT && frm_reg.bits >= 12'd24) begin
      if (frm_reg.addr[7:0] == sncfr_pkg::FEAT_BLOCK_PROTECTION &&
          !(protReg[sncfr_pkg::PROT_WRITE_LOCK_BIT] && !wpS2_reg && !quad)) begin
        if (protReg[sncfr_pkg::PROT_SOLID_BIT]) begin
          protReg <= (protReg & sncfr_pkg::PROT_SOLID_KEEP) |
                     (frm_reg.wdata & sncfr_pkg::PROT_WRITE_MASK & ~sncfr_pkg::PROT_SOLID_KEEP);
        end else begin
          protReg <= frm_reg.wdata & sncfr_pkg::PROT_WRITE_MASK;
        end
      end else if (frm_reg.addr[7:0] == sncfr_pkg::FEAT_CONFIGURATION) begin
        cfgReg <= frm_reg.wdata & sncfr_pkg::CFG_WRITE_MASK;
      end
    end
  end

  assign featSnap.prot = protReg;
  assign featSnap.cfg  = cfgReg;
  assign featSnap.stat = {1'b0, cacheBusy_reg, 4'h0, welReg, ~idle};
  assign featSnap.bank = bank_reg;

endmodule : sncfr_core

`default_nettype wire

// ---- testbench/sncfr_core_sva.sv ----
// Port-level checks of the serial NAND command block.
// Assumes binding to sncfr_core and a serial clock slower than clk_sys.
`default_nettype none

module sncfr_core_sva (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic [3:0] sioIn,
  input wire logic [3:0] sioOut,
  input wire logic [3:0] sioOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclkQ_reg;
  logic [7:0] bitCnt_reg;

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------
  // Rising serial clock edges seen in the current frame
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclkQ_reg  <= 1'b0;
      bitCnt_reg <= 8'h00;
    end else begin
      sclkQ_reg <= sclk;
      if (csN) begin
        bitCnt_reg <= 8'h00;
      end else if (sclk && !sclkQ_reg && bitCnt_reg != 8'hff) begin
        bitCnt_reg <= bitCnt_reg + 8'h01;
      end
    end
  end

  a_deselect_quiet: assert property (csN |-> sioOe == 4'h0)
    else $error("output enabled while deselected");
  a_shift_on_fall: assert property (sclk && $past(sclk) && !csN && !$past(csN)
    |-> $stable(sioOut) && $stable(sioOe)) else $error("output moved while sclk high");
  a_oe_legal_set: assert property (sioOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal output enable pattern");
  a_oe_rise_low: assert property ($rose(sioOe[1]) |-> !sclk)
    else $error("output started off a falling edge");
  a_header_first: assert property ($rose(sioOe[1]) |-> bitCnt_reg >= 8'h10)
    else $error("output before the header ended");
  a_wide_header: assert property ($rose(sioOe[0]) |-> bitCnt_reg >= 8'h20)
    else $error("wide output before address and dummy");
  a_select_gap: assert property ($fell(csN) |-> (sioOe == 4'h0)[*3])
    else $error("output at frame start");
  a_release_quiet: assert property ($rose(arst_n) |-> sioOe == 4'h0)
    else $error("output enabled after power up");
endmodule : sncfr_core_sva

bind sncfr_core sncfr_core_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n), .sclk(sclk),
  .csN(csN), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe));

`default_nettype wire

// ---- testbench/sncfr_host.sv ----
// Host controller model that frames commands in serial clock mode 0.
// Assumes the bench calls frame() and reads smp and oeSeen afterwards.
`default_nettype none

module sncfr_host (
  input  wire logic       clk_sys,
  input  wire logic [3:0] sioOut,
  input  wire logic [3:0] sioOe,
  output var  logic       sclk,
  output var  logic       csN,
  output var  logic [3:0] sioIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] smp [256];
  logic       oeSeen  = 1'b0;
  logic       wpN     = 1'b1;
  logic       hostBit = 1'b0;

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
  end

  // Driven lines show the device level; hold idles high, data keeps toggling.
  assign sioIn = (sioOe & sioOut) | (~sioOe & {1'b1, wpN, 1'b1, hostBit});

  // ----------------------------------------------------------------
  // One frame: header bits out, then samples taken on rising edges
  // ----------------------------------------------------------------
  task automatic frame(input logic [63:0] hdr, input int nHdr, input int nSmp);
    @(negedge clk_sys);
    csN = 1'b0;
    oeSeen = 1'b0;
    for (int i = 0; i < nHdr + nSmp; i++) begin
      hostBit = (i < nHdr) ? hdr[63 - i] : ~hostBit;
      #32;
      sclk = 1'b1;
      if (i >= nHdr) begin
        smp[i - nHdr] = sioIn;
      end
      oeSeen = oeSeen | (|sioOe);
      #32;
      sclk = 1'b0;
    end
    #32;
    csN = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask : frame
endmodule : sncfr_host

`default_nettype wire

// ---- testbench/sncfr_tb_top.sv ----
// Self-checking bench for the serial NAND command block.
// Assumes sncfr_host as the controller and an xorshift seed of 33.
`default_nettype none

module sncfr_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        sclk;
  logic        csN;
  logic [3:0]  sioIn;
  logic [3:0]  sioOut;
  logic [3:0]  sioOe;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  logic [31:0] rng        = 32'h0000_0021;
  logic [7:0]  ops [4]    = '{sncfr_pkg::OP_READ_X1A, sncfr_pkg::OP_READ_X1B,
                              sncfr_pkg::OP_READ_X2, sncfr_pkg::OP_READ_X4};

  always #12.5 clk_sys = ~clk_sys;

  sncfr_core #(.PROG_CYCLES(16), .ERASE_CYCLES(16)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .sclk(sclk), .csN(csN), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe));
  sncfr_host h (.clk_sys(clk_sys), .sioOut(sioOut), .sioOe(sioOe), .sclk(sclk), .csN(csN),
    .sioIn(sioIn));

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd

  function automatic logic [7:0] cb(input logic [16:0] row, input logic [11:0] col);
    return row[7:0] ^ col[7:0] ^ {4'h0, col[11:8]};
  endfunction : cb

  function automatic logic [11:0] nxt(input logic [11:0] c, input logic [1:0] s);
    logic [11:0] len;
    len = (s == 2'h0) ? 12'h840 : (s == 2'h1) ? 12'h800 : (s == 2'h2) ? 12'h040 : 12'h010;
    return ((c + 12'h001) % len == 12'h000) ? c + 12'h001 - len : c + 12'h001;
  endfunction : nxt

  function automatic logic [7:0] byteAt(input int k, input int w);
    logic [7:0] b;
    b = 8'h00;
    for (int j = 0; j < 8 / w; j++) begin
      b = (w == 1) ? {b[6:0], h.smp[k * 8 + j][1]} :
          (w == 2) ? {b[5:0], h.smp[k * 4 + j][1:0]} : {b[3:0], h.smp[k * 2 + j]};
    end
    return b;
  endfunction : byteAt

  task automatic getf(input logic [7:0] a, output logic [7:0] v);
    h.frame({sncfr_pkg::OP_GET_FEAT, a, 48'h0}, 16, 8);
    v = byteAt(0, 1);
  endtask : getf

  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    h.frame({sncfr_pkg::OP_SET_FEAT, a, d, 40'h0}, 24, 0);
  endtask : setf

  task automatic cmd(input logic [7:0] op);
    h.frame({op, 56'h0}, 8, 0);
  endtask : cmd

  task automatic cread(input logic [7:0] op, input logic [15:0] a, input int w, input int n);
    h.frame({op, a, 8'h00, 32'h0}, 32, n * 8 / w);
  endtask : cread

  task automatic waitReady();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 500 && s[0] !== 1'b0; i++) getf(8'hc0, s);
    check8(s & 8'h01, 8'h00);
  endtask : waitReady

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0]  v;
    logic [7:0]  e;
    logic [7:0]  r;
    logic [16:0] row;
    logic [11:0] col;
    logic [1:0]  s;
    int          w;
    repeat (16) @(negedge clk_sys);
    arst_n = 1'b1;
    getf(8'ha0, v);
    check8(v, sncfr_pkg::PROT_RESET);
    getf(8'hb0, v);
    check8(v, sncfr_pkg::CFG_RESET);
    waitReady();
    cread(sncfr_pkg::OP_READ_X1A, 16'h0005, 1, 2);
    check8(byteAt(1, 1), cb(17'h0, 12'h006));
    h.frame({sncfr_pkg::OP_READ_ID, 56'h0}, 16, 16);
    check8(byteAt(0, 1), sncfr_pkg::ID_MAKER);
    check8(byteAt(1, 1), sncfr_pkg::ID_DEVICE);
    cmd(sncfr_pkg::OP_LATCH_SET);
    getf(8'hc0, v);
    check8(v & 8'h03, 8'h02);
    for (int i = 0; i < 2; i++) begin
      cmd(i ? sncfr_pkg::OP_LATCH_SET : sncfr_pkg::OP_LATCH_CLEAR);
      h.frame({sncfr_pkg::OP_BLOCK_ERASE, 24'h000040, 32'h0}, 32, 0);
      getf(8'hc0, v);
      check8(v & 8'h03, 8'h00);
    end
    $display("test power_up_id_latch done");
    for (int i = 0; i < 6; i++) begin
      e = rnd() & 8'h3e;
      setf(8'ha0, e);
      getf(8'ha0, v);
      getf(8'ha0, v);
      check8(v, e);
      e = rnd() & 8'h11;
      setf(8'hb0, e);
      getf(8'hb0, v);
      check8(v, e);
    end
    setf(8'ha0, 8'h28);
    cmd(sncfr_pkg::OP_RESET);
    getf(8'hc0, v);
    check8(v & 8'h01, 8'h01);
    waitReady();
    getf(8'ha0, v);
    check8(v, 8'h28);
    setf(8'hb0, 8'h10);
    setf(8'ha0, 8'ha8);
    h.wpN = 1'b0;
    setf(8'ha0, 8'h00);
    getf(8'ha0, v);
    check8(v, 8'ha8);
    h.wpN = 1'b1;
    setf(8'ha0, 8'h01);
    setf(8'ha0, 8'h3e);
    getf(8'ha0, v);
    check8(v, 8'h01);
    cread(sncfr_pkg::OP_READ_X4, 16'h0000, 4, 2);
    check8({7'h0, h.oeSeen}, 8'h00);
    h.frame({8'h77, 56'h0}, 8, 24);
    check8({7'h0, h.oeSeen}, 8'h00);
    $display("test features done");
    setf(8'hb0, 8'h11);
    row = {9'h000, rnd()};
    h.frame({sncfr_pkg::OP_PAGE_READ, 7'h00, row, 32'h0}, 32, 0);
    waitReady();
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      s = k[2:1];
      col = (k == 0) ? 12'h83c : {1'b0, r[2:0], rnd()};
      w = (k % 4 == 3) ? 4 : (k % 4 == 2) ? 2 : 1;
      cread(ops[k % 4], {2'b00, s, col}, w, 20);
      for (int j = 0; j < 20; j++) begin
        check8(byteAt(j, w), cb(row, col));
        col = nxt(col, s);
      end
    end
    $display("test page_wrap done");
    row = 17'h0003f;
    h.frame({sncfr_pkg::OP_PAGE_READ, 7'h00, row, 32'h0}, 32, 0);
    waitReady();
    for (int k = 1; k < 3; k++) begin
      cmd((k == 1) ? sncfr_pkg::OP_SEQ_READ : sncfr_pkg::OP_SEQ_END);
      waitReady();
      cread(sncfr_pkg::OP_READ_X1A, 16'h0000, 1, 1);
      check8(byteAt(0, 1), cb(row + 17'(k), 12'h000));
    end
    $display("test sequential done");
    report_and_stop();
  end
endmodule : sncfr_tb_top

`default_nettype wire
